/* design/dual_dac_register_control.v */
// Operation
// RQ1: Control bit 7 set selects 8-bit codes from low bytes; clear selects 12-bit.
// RQ2: Control bit 6 picks channel 1 span: 1 full supply, 0 reference.
// RQ3: Control bit 5 picks channel 0 span: 1 full supply, 0 reference.
// RQ4: Bits 4 and 3 low force channel 1 or 0 output to zero.
// RQ5: With bit 2 set, writing a low byte loads that channel's output.
// RQ6: With bit 2 clear writes are held; setting it loads both channels together.
// RQ7: Bits 1 and 0 power channels on; clear means off and high impedance.
// RQ8: Control register resets to 04H, so both channels start powered off.
// RQ9: A 12-bit code is low byte plus low nibble of high byte.
// RQ10: Software writes high byte before low byte in immediate 12-bit updates.
// RQ11: High byte upper nibble is ignored; high bytes unused in 8-bit mode.
`timescale 1ns/1ps
`include "dual_dac_regs.vh"
module dual_dac_register_control (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire [7:0] sfr_addr_in,
  input wire [7:0] sfr_wdata_in,
  input wire sfr_write_in,
  input wire sfr_read_in,
  output reg [7:0] sfr_rdata_out,
  output reg sfr_hit_out,
  output wire [11:0] chan0_code_out,
  output wire [11:0] chan1_code_out,
  output wire chan0_span_select_out,
  output wire chan1_span_select_out,
  output wire chan0_force_zero_n_out,
  output wire chan1_force_zero_n_out,
  output wire chan0_power_on_out,
  output wire chan1_power_on_out
);
  reg rst_sync1_q;
  reg rst_sync2_q;
  reg [7:0] converter_control_q;
  reg [7:0] chan0_data_low_q;
  reg [7:0] chan0_data_high_q;
  reg [7:0] chan1_data_low_q;
  reg [7:0] chan1_data_high_q;
  reg load0_d;
  reg load1_d;
  reg [7:0] rdata_d;
  reg hit_d;
  wire [2:0] bus_index;
  wire wr_ctrl;
  wire wr_low0;
  wire wr_high0;
  wire wr_low1;
  wire wr_high1;
  wire sync_rise;
  wire [11:0] code0_d;
  wire [11:0] code1_d;

  localparam [2:0] IDX_CHAN0_LOW = 3'h0;
  localparam [2:0] IDX_CHAN0_HIGH = 3'h1;
  localparam [2:0] IDX_CHAN1_LOW = 3'h2;
  localparam [2:0] IDX_CHAN1_HIGH = 3'h3;
  localparam [2:0] IDX_CONTROL = 3'h4;
  localparam [2:0] IDX_NONE = 3'h7;

  // Maps a bus address onto the register it selects, shared by the write and read paths.
  function [2:0] reg_index;
    input [7:0] addr;
    begin
      case (addr)
        `ADDR_CHAN0_DATA_LOW: reg_index = IDX_CHAN0_LOW;
        `ADDR_CHAN0_DATA_HIGH: reg_index = IDX_CHAN0_HIGH;
        `ADDR_CHAN1_DATA_LOW: reg_index = IDX_CHAN1_LOW;
        `ADDR_CHAN1_DATA_HIGH: reg_index = IDX_CHAN1_HIGH;
        `ADDR_CONVERTER_CONTROL: reg_index = IDX_CONTROL;
        default: reg_index = IDX_NONE;
      endcase
    end
  endfunction

  function [11:0] form_code;
    input eight_bit;
    input [7:0] low_byte;
    input [7:0] high_byte;
    begin
      if (eight_bit) begin
        form_code = {low_byte, 4'h0}; // RQ1 RQ11
      end else begin
        form_code = {high_byte[3:0], low_byte}; // RQ9 RQ11
      end
    end
  endfunction

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  assign bus_index = reg_index(sfr_addr_in);
  assign wr_ctrl = sfr_write_in && (bus_index == IDX_CONTROL);
  assign wr_low0 = sfr_write_in && (bus_index == IDX_CHAN0_LOW);
  assign wr_high0 = sfr_write_in && (bus_index == IDX_CHAN0_HIGH);
  assign wr_low1 = sfr_write_in && (bus_index == IDX_CHAN1_LOW);
  assign wr_high1 = sfr_write_in && (bus_index == IDX_CHAN1_HIGH);
  assign sync_rise = wr_ctrl && sfr_wdata_in[`BIT_UPDATE_SYNC] && !converter_control_q[`BIT_UPDATE_SYNC];

  always @(posedge clk_sys_in or negedge rst_sync2_q) begin
    if (!rst_sync2_q) begin
      converter_control_q <= `CTRL_RESET; // RQ8
    end else if (wr_ctrl) begin
      converter_control_q <= sfr_wdata_in;
    end
  end

  always @(posedge clk_sys_in or negedge rst_sync2_q) begin
    if (!rst_sync2_q) begin
      chan0_data_low_q <= `DATA_RESET;
    end else if (wr_low0) begin
      chan0_data_low_q <= sfr_wdata_in;
    end
  end

  always @(posedge clk_sys_in or negedge rst_sync2_q) begin
    if (!rst_sync2_q) begin
      chan0_data_high_q <= `DATA_RESET;
    end else if (wr_high0) begin
      chan0_data_high_q <= sfr_wdata_in;
    end
  end

  always @(posedge clk_sys_in or negedge rst_sync2_q) begin
    if (!rst_sync2_q) begin
      chan1_data_low_q <= `DATA_RESET;
    end else if (wr_low1) begin
      chan1_data_low_q <= sfr_wdata_in;
    end
  end

  always @(posedge clk_sys_in or negedge rst_sync2_q) begin
    if (!rst_sync2_q) begin
      chan1_data_high_q <= `DATA_RESET;
    end else if (wr_high1) begin
      chan1_data_high_q <= sfr_wdata_in;
    end
  end

  always @(posedge clk_sys_in or negedge rst_sync2_q) begin
    if (!rst_sync2_q) begin
      sfr_rdata_out <= 8'h00;
      sfr_hit_out <= 1'b0;
    end else begin
      sfr_rdata_out <= rdata_d;
      sfr_hit_out <= hit_d;
    end
  end

  always @* begin
    hit_d = 1'b1;
    case (bus_index)
      IDX_CHAN0_LOW: rdata_d = chan0_data_low_q;
      IDX_CHAN0_HIGH: rdata_d = chan0_data_high_q;
      IDX_CHAN1_LOW: rdata_d = chan1_data_low_q;
      IDX_CHAN1_HIGH: rdata_d = chan1_data_high_q;
      IDX_CONTROL: rdata_d = converter_control_q;
      default: begin
        rdata_d = 8'h00;
        hit_d = 1'b0;
      end
    endcase
    if (!sfr_read_in) begin
      rdata_d = 8'h00;
      hit_d = 1'b0;
    end
  end

  // Load strobes are registered so the code uses bytes already stored.
  always @* begin
    load0_d = (wr_low0 && converter_control_q[`BIT_UPDATE_SYNC]) || sync_rise; // RQ5 RQ6
    load1_d = (wr_low1 && converter_control_q[`BIT_UPDATE_SYNC]) || sync_rise; // RQ5 RQ6
  end

  reg load0_q;
  reg load1_q;
  always @(posedge clk_sys_in or negedge rst_sync2_q) begin
    if (!rst_sync2_q) begin
      load0_q <= 1'b0;
      load1_q <= 1'b0;
    end else begin
      load0_q <= load0_d;
      load1_q <= load1_d;
    end
  end

  assign code0_d = form_code(converter_control_q[`BIT_WIDTH_SELECT], chan0_data_low_q, chan0_data_high_q);
  assign code1_d = form_code(converter_control_q[`BIT_WIDTH_SELECT], chan1_data_low_q, chan1_data_high_q);

  dac_channel_out u_chan0 (
    .clk_in(clk_sys_in),
    .rst_n_in(rst_sync2_q),
    .load_in(load0_q),
    .code_in(code0_d),
    .span_in(converter_control_q[`BIT_CHAN0_SPAN_SELECT]), // RQ3
    .force_zero_n_in(converter_control_q[`BIT_CHAN0_FORCE_ZERO_N]), // RQ4
    .power_on_in(converter_control_q[`BIT_CHAN0_POWER_ON]), // RQ7
    .code_out(chan0_code_out),
    .span_out(chan0_span_select_out),
    .force_zero_n_out(chan0_force_zero_n_out),
    .power_on_out(chan0_power_on_out)
  );

  dac_channel_out u_chan1 (
    .clk_in(clk_sys_in),
    .rst_n_in(rst_sync2_q),
    .load_in(load1_q),
    .code_in(code1_d),
    .span_in(converter_control_q[`BIT_CHAN1_SPAN_SELECT]), // RQ2
    .force_zero_n_in(converter_control_q[`BIT_CHAN1_FORCE_ZERO_N]), // RQ4
    .power_on_in(converter_control_q[`BIT_CHAN1_POWER_ON]), // RQ7
    .code_out(chan1_code_out),
    .span_out(chan1_span_select_out),
    .force_zero_n_out(chan1_force_zero_n_out),
    .power_on_out(chan1_power_on_out)
  );
endmodule

/* design/dual_dac_regs.vh */
`ifndef DUAL_DAC_REGS_VH
`define DUAL_DAC_REGS_VH
`define ADDR_CHAN0_DATA_LOW 8'hF9
`define ADDR_CHAN0_DATA_HIGH 8'hFA
`define ADDR_CHAN1_DATA_LOW 8'hFB
`define ADDR_CHAN1_DATA_HIGH 8'hFC
`define ADDR_CONVERTER_CONTROL 8'hFD
`define CTRL_RESET 8'h04
`define DATA_RESET 8'h00
`define BIT_WIDTH_SELECT 7
`define BIT_CHAN1_SPAN_SELECT 6
`define BIT_CHAN0_SPAN_SELECT 5
`define BIT_CHAN1_FORCE_ZERO_N 4
`define BIT_CHAN0_FORCE_ZERO_N 3
`define BIT_UPDATE_SYNC 2
`define BIT_CHAN1_POWER_ON 1
`define BIT_CHAN0_POWER_ON 0
`endif

/* design/dac_channel_out.v */
`timescale 1ns/1ps
// Holds the code presented to one converter and its analog control levels.
module dac_channel_out (
  input wire clk_in,
  input wire rst_n_in,
  input wire load_in,
  input wire [11:0] code_in,
  input wire span_in,
  input wire force_zero_n_in,
  input wire power_on_in,
  output reg [11:0] code_out,
  output reg span_out,
  output reg force_zero_n_out,
  output reg power_on_out
);
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      code_out <= 12'h000;
      span_out <= 1'b0;
      force_zero_n_out <= 1'b0;
      power_on_out <= 1'b0;
    end else begin
      if (load_in) begin
        code_out <= code_in;
      end
      span_out <= span_in;
      force_zero_n_out <= force_zero_n_in;
      power_on_out <= power_on_in;
    end
  end
endmodule

/* sim/dual_dac_register_control_sva.sv */
`timescale 1ns/1ps
module dual_dac_sva (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire sfr_write_in,
  input wire sfr_read_in,
  input wire [7:0] sfr_addr_in,
  input wire [7:0] sfr_wdata_in,
  input wire [7:0] sfr_rdata_out,
  input wire sfr_hit_out,
  input wire [11:0] chan0_code_out,
  input wire [11:0] chan1_code_out,
  input wire chan0_span_select_out,
  input wire chan1_span_select_out,
  input wire chan0_force_zero_n_out,
  input wire chan1_force_zero_n_out,
  input wire chan0_power_on_out,
  input wire chan1_power_on_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  sequence ctl_wr;
    sfr_write_in && sfr_addr_in == 8'hFD;
  endsequence
  AST_SPAN1: assert property (ctl_wr |-> ##2
    chan1_span_select_out == $past(sfr_wdata_in[6], 2)) else $error("span 1 wrong");
  AST_SPAN0: assert property (ctl_wr |-> ##2
    chan0_span_select_out == $past(sfr_wdata_in[5], 2)) else $error("span 0 wrong");
  AST_ZERO: assert property (ctl_wr |-> ##2
    {chan1_force_zero_n_out, chan0_force_zero_n_out} == $past(sfr_wdata_in[4:3], 2)) else $error("clear wrong");
  AST_POWER: assert property (ctl_wr |-> ##2
    {chan1_power_on_out, chan0_power_on_out} == $past(sfr_wdata_in[1:0], 2)) else $error("power wrong");
  AST_CODE0: assert property ($changed(chan0_code_out) |-> $past(sfr_write_in, 2) &&
    ($past(sfr_addr_in, 2) == 8'hF9 || $past(sfr_addr_in, 2) == 8'hFD)) else $error("code 0 moved");
  AST_CODE1: assert property ($changed(chan1_code_out) |-> $past(sfr_write_in, 2) &&
    ($past(sfr_addr_in, 2) == 8'hFB || $past(sfr_addr_in, 2) == 8'hFD)) else $error("code 1 moved");
  AST_HIT: assert property (sfr_read_in && sfr_addr_in == 8'hFD |=> sfr_hit_out) else $error("no hit");
  AST_MISS: assert property (sfr_read_in && sfr_addr_in < 8'hF9 |=> !sfr_hit_out && sfr_rdata_out == 8'h00)
    else $error("unmapped hit");
endmodule
bind dual_dac_register_control dual_dac_sva dual_dac_sva_i (
  .clk_sys_in(clk_sys_in),
  .arst_n_in(arst_n_in),
  .sfr_write_in(sfr_write_in),
  .sfr_read_in(sfr_read_in),
  .sfr_addr_in(sfr_addr_in),
  .sfr_wdata_in(sfr_wdata_in),
  .sfr_rdata_out(sfr_rdata_out),
  .sfr_hit_out(sfr_hit_out),
  .chan0_code_out(chan0_code_out),
  .chan1_code_out(chan1_code_out),
  .chan0_span_select_out(chan0_span_select_out),
  .chan1_span_select_out(chan1_span_select_out),
  .chan0_force_zero_n_out(chan0_force_zero_n_out),
  .chan1_force_zero_n_out(chan1_force_zero_n_out),
  .chan0_power_on_out(chan0_power_on_out),
  .chan1_power_on_out(chan1_power_on_out)
);

/* sim/dual_dac_register_control_test.sv */
`timescale 1ns/1ps
module dual_dac_register_control_test;
  logic clk_sys_in = 0, arst_n_in = 0, sfr_write_in = 0, sfr_read_in = 0, ch, m;
  logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, lo, hi;
  wire [7:0] sfr_rdata_out;
  wire [11:0] chan0_code_out, chan1_code_out;
  wire sfr_hit_out, chan0_span_select_out, chan1_span_select_out, chan0_force_zero_n_out;
  wire chan1_force_zero_n_out, chan0_power_on_out, chan1_power_on_out;
  wire [5:0] ctl_seen = {chan1_span_select_out, chan0_span_select_out, chan1_force_zero_n_out,
    chan0_force_zero_n_out, chan1_power_on_out, chan0_power_on_out};
  int error_cnt = 0, n_compared = 0;
  logic [31:0] seed = 32'h42, r;
  logic [11:0] e0 = 12'h000, e1 = 12'h000;
  always #50 clk_sys_in = ~clk_sys_in;
  dual_dac_register_control dual_dac_register_control_i (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .sfr_addr_in(sfr_addr_in),
    .sfr_wdata_in(sfr_wdata_in),
    .sfr_write_in(sfr_write_in),
    .sfr_read_in(sfr_read_in),
    .sfr_rdata_out(sfr_rdata_out),
    .sfr_hit_out(sfr_hit_out),
    .chan0_code_out(chan0_code_out),
    .chan1_code_out(chan1_code_out),
    .chan0_span_select_out(chan0_span_select_out),
    .chan1_span_select_out(chan1_span_select_out),
    .chan0_force_zero_n_out(chan0_force_zero_n_out),
    .chan1_force_zero_n_out(chan1_force_zero_n_out),
    .chan0_power_on_out(chan0_power_on_out),
    .chan1_power_on_out(chan1_power_on_out)
  );
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [11:0] exp_code(input logic md, input logic [7:0] l, input logic [7:0] h);
    return md ? {l, 4'h0} : {h[3:0], l};
  endfunction
  task cmp(input logic [11:0] g, input logic [11:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cmp_ctl(input logic [5:0] e);
    n_compared++;
    if (ctl_seen !== e) begin
      error_cnt++;
      $display("FAIL %0t control fields got %h exp %h", $time, ctl_seen, e);
    end
  endtask
  task wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_write_in <= 1'b1;
    @(posedge clk_sys_in);
    sfr_write_in <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge clk_sys_in);
    sfr_addr_in <= a;
    sfr_read_in <= 1'b1;
    @(posedge clk_sys_in);
    sfr_read_in <= 1'b0;
    #1;
    cmp({4'h0, sfr_rdata_out}, {4'h0, e});
    cmp({11'h0, sfr_hit_out}, {11'h0, h});
  endtask
  task chk();
    repeat (3) @(posedge clk_sys_in);
    #1;
    cmp(chan0_code_out, e0);
    cmp(chan1_code_out, e1);
  endtask
  task stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    for (int i = 0; i < 5; i++) rdc(8'hF9 + i[7:0], i == 4 ? 8'h04 : 8'h00, 1'b1);
    rdc(8'hF8, 8'h00, 1'b0);
    cmp({10'h0, chan1_power_on_out, chan0_power_on_out}, 12'h000);
    cmp_ctl(6'h00);
    for (int i = 0; i < 30; i++) begin
      r = xs();
      m = r[7];
      ch = r[8];
      hi = r[23:16];
      lo = r[31:24];
      wrt(8'hFD, {r[7:3], 1'b1, r[1:0]});
      wrt(8'hFA + {6'h0, ch, 1'b0}, hi);
      wrt(8'hF9 + {6'h0, ch, 1'b0}, lo);
      if (ch) e1 = exp_code(m, lo, hi);
      else e0 = exp_code(m, lo, hi);
      chk();
      cmp_ctl({r[6:3], r[1:0]});
      rdc(8'hFA + {6'h0, ch, 1'b0}, hi, 1'b1);
    end
    wrt(8'hFD, 8'h1B);
    r = xs();
    wrt(8'hFA, r[7:0]);
    wrt(8'hF9, r[15:8]);
    wrt(8'hFC, r[23:16]);
    wrt(8'hFB, r[31:24]);
    chk();
    wrt(8'hFD, 8'h1F);
    e0 = exp_code(1'b0, r[15:8], r[7:0]);
    e1 = exp_code(1'b0, r[31:24], r[23:16]);
    chk();
    cmp_ctl(6'h0F);
    stop_test();
  end
endmodule
